// ---- memory_map_pkg.sv ----
// Constants and types for the address map and boot environment logic.
package memory_map_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int ADDR_W  = 24;
   localparam int PIN_W   = 3;
   localparam int EMPTY_W = 2;

   // ************************************************************
   // Region bounds, inclusive
   // ************************************************************
   localparam logic [23:0] PROG_FLASH_LO  = 24'h000000;
   localparam logic [23:0] PROG_FLASH_HI  = 24'h03ffff;
   localparam logic [23:0] DATA_FLASH_LO  = 24'h0d0000;
   localparam logic [23:0] DATA_FLASH_HI  = 24'h0d1fff;
   localparam logic [23:0] SYS_RAM_LO     = 24'h0e0000;
   localparam logic [23:0] SYS_RAM_HI     = 24'h0e7fff;
   localparam logic [23:0] LINK_RAM_LO    = 24'h0e8000;
   localparam logic [23:0] LINK_RAM_HI    = 24'h0e91ff;
   localparam logic [23:0] SEQ_RAM_LO     = 24'h0ee800;
   localparam logic [23:0] SEQ_RAM_HI     = 24'h0eebff;
   localparam logic [23:0] CAN_LO         = 24'h0ef000;
   localparam logic [23:0] CAN_HI         = 24'h0ef13f;
   localparam logic [23:0] LINK_REGS_LO   = 24'h0ef180;
   localparam logic [23:0] LINK_REGS_HI   = 24'h0ef1ff;
   localparam logic [23:0] EXT_ZONE1_LO   = 24'h400000;
   localparam logic [23:0] EXT_ZONE1_HI   = 24'h7fffff;
   localparam logic [23:0] EXT_ZONE2_LO   = 24'h800000;
   localparam logic [23:0] EXT_ZONE2_HI   = 24'hfeffff;
   localparam logic [23:0] PERIPH_A_LO    = 24'hfff200;
   localparam logic [23:0] PERIPH_A_HI    = 24'hfff5ff;
   localparam logic [23:0] BUS_CTRL_LO    = 24'hfff600;
   localparam logic [23:0] BUS_CTRL_HI    = 24'hfffaff;
   localparam logic [23:0] IO_EXP_LO      = 24'hfffb00;
   localparam logic [23:0] IO_EXP_HI      = 24'hfffbff;
   localparam logic [23:0] PERIPH_B_LO    = 24'hfffc00;
   localparam logic [23:0] PERIPH_B_HI    = 24'hffffff;

   // ************************************************************
   // Environment pin codes and sampling
   // ************************************************************
   localparam logic [2:0] PINS_RESET_VALUE = 3'h7;
   localparam logic [2:0] CODE_INT_ROM     = 3'h7;
   localparam logic [2:0] CODE_EXT_ROM     = 3'h3;
   localparam logic [2:0] CODE_PROGRAM     = 3'h6;
   localparam logic [2:0] CODE_DEVELOP     = 3'h0;
   localparam logic [2:0] CODE_DEVELOP_INT = 3'h1;
   localparam logic [1:0] FLASH_EMPTY_ALL  = 2'h3;
   localparam logic [1:0] SETTLE_COUNT     = 2'h2;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [3:0] {
      region_reserved, region_prog_flash, region_data_flash,
      region_system_ram, region_link_data_ram, region_sequencer_ram,
      region_can, region_link_regs, region_ext_zone1,
      region_ext_zone2, region_peripheral, region_bus_ctrl,
      region_io_expansion
   } region_e;

   typedef enum logic [2:0] {
      zone_none, zone_static0, zone_static1, zone_static2, zone_io
   } zone_e;

   typedef enum logic [2:0] {
      internal_rom_mode, external_rom_mode, in_system_programming_mode,
      development_mode, development_internal_memory_mode
   } mode_e;

   function automatic logic in_range(input logic [23:0] a,
                                     input logic [23:0] lo,
                                     input logic [23:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

endpackage

// ---- environment_pin_sync.sv ----
// Two-stage synchroniser for the environment select pins.
`timescale 1ns/1ps
module environment_pin_sync (
   input  wire logic                             clk_sys,
   input  wire logic                             reset,
   input  wire logic                             clk_en,
   input  wire logic [memory_map_pkg::PIN_W-1:0] pins_async,
   output logic      [memory_map_pkg::PIN_W-1:0] pins_synced
);
   import memory_map_pkg::*;

   logic [PIN_W-1:0] stage1_reg;
   logic [PIN_W-1:0] stage2_reg;

   // Reset to ones, as the pull-ups give on floating pins.
   for (genvar i = 0; i < PIN_W; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
         if (reset) begin
            stage1_reg[i] <= PINS_RESET_VALUE[i];
            stage2_reg[i] <= PINS_RESET_VALUE[i];
         end else if (clk_en) begin
            stage1_reg[i] <= pins_async[i];
            stage2_reg[i] <= stage1_reg[i];
         end
      end
   end

   assign pins_synced = stage2_reg;

endmodule // environment_pin_sync

// ---- address_region_decoder.sv ----
// Combinational address decoder for the 16 MB map.
`timescale 1ns/1ps
module address_region_decoder (
   input  wire logic [memory_map_pkg::ADDR_W-1:0] addr,
   input  wire memory_map_pkg::mode_e             mode,
   output memory_map_pkg::region_e                region,
   output memory_map_pkg::zone_e                  zone,
   output logic                                   to_external,
   output logic                                   reserved
);
   import memory_map_pkg::*;

   logic ext_enabled;

   // Priority order does not matter: the ranges never overlap.
   always_comb begin
      region = region_reserved;
      zone   = zone_none;
      if (in_range(addr, PROG_FLASH_LO, PROG_FLASH_HI)) begin
         region = region_prog_flash;
         zone   = zone_static0;
      end else if (in_range(addr, DATA_FLASH_LO, DATA_FLASH_HI)) begin
         region = region_data_flash;
         zone   = zone_static0;
      end else if (in_range(addr, SYS_RAM_LO, SYS_RAM_HI)) begin
         region = region_system_ram;
      end else if (in_range(addr, LINK_RAM_LO, LINK_RAM_HI)) begin
         region = region_link_data_ram;
      end else if (in_range(addr, SEQ_RAM_LO, SEQ_RAM_HI)) begin
         region = region_sequencer_ram;
      end else if (in_range(addr, CAN_LO, CAN_HI)) begin
         region = region_can;
      end else if (in_range(addr, LINK_REGS_LO, LINK_REGS_HI)) begin
         region = region_link_regs;
      end else if (in_range(addr, EXT_ZONE1_LO, EXT_ZONE1_HI)) begin
         region = region_ext_zone1;
         zone   = zone_static1;
      end else if (in_range(addr, EXT_ZONE2_LO, EXT_ZONE2_HI)) begin
         region = region_ext_zone2;
         zone   = zone_static2;
      end else if (in_range(addr, PERIPH_A_LO, PERIPH_A_HI) ||
                   in_range(addr, PERIPH_B_LO, PERIPH_B_HI)) begin
         region = region_peripheral;
      end else if (in_range(addr, BUS_CTRL_LO, BUS_CTRL_HI)) begin
         region = region_bus_ctrl;
      end else if (in_range(addr, IO_EXP_LO, IO_EXP_HI)) begin
         region = region_io_expansion;
         zone   = zone_io;
      end
   end

   // External memory is only wired up in the modes that support it.
   assign ext_enabled = (mode == external_rom_mode) ||
                        (mode == development_mode) ||
                        (mode == development_internal_memory_mode);

   always_comb begin
      to_external = 1'b0;
      reserved    = (region == region_reserved);
      if (zone == zone_static0) begin
         to_external = (mode == development_mode);
      end else if (zone == zone_static1 || zone == zone_static2) begin
         to_external = ext_enabled;
         reserved    = !ext_enabled;
      end
   end

endmodule // address_region_decoder

// ---- memory_map_and_boot_env.sv ----
// Top of the address map decoder and boot environment selection.
//
// What this block does
// - Decode flat 16 MB space, one region each.
// - Program flash at 000000h to 03FFFFh, zone 0.
// - Data flash at 0D0000h to 0D1FFFh.
// - Sequencer RAM 1K ends 0EEBFFh, no zone.
// - CAN area of 320 bytes ends 0EF13Fh.
// - Link registers at 0EF180h to 0EF1FFh.
// - 400000h to 7FFFFFh external, static zone 1.
// - 800000h to FEFFFFh external, static zone 2.
// - Peripheral ports decoded, no zone attached.
// - Bus, DMA, flash controls at FFF600h-FFFAFFh.
// - Up to 12M external when external enabled.
// - Mode from sampled pins and flash-empty flags.
// - Floating pins read as all ones.
// - Code 111 internal ROM, programming if empty.
// - Code 011 external ROM, programming if empty.
// - Code 110 always programming mode.
// - Programming mode uses programming reset vector.
// - Development mode sends flash region external.
// - Development internal keeps zone 0 on-chip.
// - ROM modes map zone 0 to internal flash.
// - Code 000 development, 001 development internal.
`timescale 1ns/1ps
module memory_map_and_boot_env (
   input  wire logic                               clk_sys,
   input  wire logic                               reset,
   input  wire logic                               clk_en,
   input  wire logic [memory_map_pkg::PIN_W-1:0]   environment_select_pins,
   input  wire logic [memory_map_pkg::EMPTY_W-1:0] flash_empty_flags,
   input  wire logic                               req_valid,
   input  wire logic                               req_write,
   input  wire logic [memory_map_pkg::ADDR_W-1:0]  req_addr,
   output memory_map_pkg::mode_e                   operating_mode,
   output logic                                    mode_ready,
   output logic                                    programming_vector,
   output logic                                    external_enabled,
   output logic                                    rsp_valid,
   output logic                                    rsp_write,
   output logic      [memory_map_pkg::ADDR_W-1:0]  rsp_addr,
   output memory_map_pkg::region_e                 rsp_region,
   output memory_map_pkg::zone_e                   rsp_zone,
   output logic                                    rsp_external,
   output logic                                    rsp_reserved
);
   import memory_map_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [PIN_W-1:0]  pins_synced;
   logic              flash_empty;
   logic              capture;
   logic              taken;
   mode_e             mode_next;
   region_e           dec_region;
   zone_e             dec_zone;
   logic              dec_external;
   logic              dec_reserved;

   logic [1:0]        sample_count_reg;
   mode_e             mode_reg;
   logic              mode_ready_reg;
   logic              programming_vector_reg;
   logic              external_enabled_reg;
   logic              rsp_valid_reg;
   logic              rsp_write_reg;
   logic [ADDR_W-1:0] rsp_addr_reg;
   region_e           rsp_region_reg;
   zone_e             rsp_zone_reg;
   logic              rsp_external_reg;
   logic              rsp_reserved_reg;

   // ************************************************************
   // Pin synchroniser and decoder
   // ************************************************************
   environment_pin_sync u_pin_sync (
      .clk_sys     (clk_sys),
      .reset       (reset),
      .clk_en      (clk_en),
      .pins_async  (environment_select_pins),
      .pins_synced (pins_synced)
   );

   address_region_decoder u_decoder (
      .addr        (req_addr),
      .mode        (mode_reg),
      .region      (dec_region),
      .zone        (dec_zone),
      .to_external (dec_external),
      .reserved    (dec_reserved)
   );

   // ************************************************************
   // Environment selection
   // ************************************************************
   // Program flash counts as empty only when every flag says so.
   assign flash_empty = (flash_empty_flags == FLASH_EMPTY_ALL);

   always_comb begin
      case (pins_synced)
         CODE_INT_ROM: begin
            mode_next = flash_empty ? in_system_programming_mode
                                    : internal_rom_mode;
         end
         CODE_EXT_ROM: begin
            mode_next = flash_empty ? in_system_programming_mode
                                    : external_rom_mode;
         end
         CODE_PROGRAM: begin
            mode_next = in_system_programming_mode;
         end
         CODE_DEVELOP: begin
            mode_next = development_mode;
         end
         CODE_DEVELOP_INT: begin
            mode_next = development_internal_memory_mode;
         end
         default: begin
            // Unassigned codes behave like floating pins.
            mode_next = flash_empty ? in_system_programming_mode
                                    : internal_rom_mode;
         end
      endcase
   end

   // The synchroniser needs two edges after release before its
   // output shows the real pins, so capture waits for them.
   assign capture = clk_en && !mode_ready_reg &&
                    (sample_count_reg == SETTLE_COUNT);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sample_count_reg <= 2'h0;
      end else if (clk_en && !mode_ready_reg &&
                   sample_count_reg != SETTLE_COUNT) begin
         sample_count_reg <= sample_count_reg + 2'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mode_reg               <= internal_rom_mode;
         mode_ready_reg         <= 1'b0;
         programming_vector_reg <= 1'b0;
         external_enabled_reg   <= 1'b0;
      end else if (capture) begin
         mode_reg       <= mode_next;
         mode_ready_reg <= 1'b1;
         programming_vector_reg <=
            (mode_next == in_system_programming_mode);
         external_enabled_reg <=
            (mode_next == external_rom_mode) ||
            (mode_next == development_mode) ||
            (mode_next == development_internal_memory_mode);
      end
   end

   // ************************************************************
   // Access decode
   // ************************************************************
   // Requests before the mode is known are dropped, since the
   // routing of zone 0 and the external zones depends on it.
   assign taken = clk_en && req_valid && mode_ready_reg;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rsp_valid_reg <= 1'b0;
      end else if (clk_en) begin
         rsp_valid_reg <= taken;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rsp_write_reg    <= 1'b0;
         rsp_addr_reg     <= '0;
         rsp_region_reg   <= region_reserved;
         rsp_zone_reg     <= zone_none;
         rsp_external_reg <= 1'b0;
         rsp_reserved_reg <= 1'b0;
      end else if (taken) begin
         rsp_write_reg    <= req_write;
         rsp_addr_reg     <= req_addr;
         rsp_region_reg   <= dec_region;
         rsp_zone_reg     <= dec_zone;
         rsp_external_reg <= dec_external;
         rsp_reserved_reg <= dec_reserved;
      end
   end

   assign operating_mode     = mode_reg;
   assign mode_ready         = mode_ready_reg;
   assign programming_vector = programming_vector_reg;
   assign external_enabled   = external_enabled_reg;
   assign rsp_valid          = rsp_valid_reg;
   assign rsp_write          = rsp_write_reg;
   assign rsp_addr           = rsp_addr_reg;
   assign rsp_region         = rsp_region_reg;
   assign rsp_zone           = rsp_zone_reg;
   assign rsp_external       = rsp_external_reg;
   assign rsp_reserved       = rsp_reserved_reg;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   sequence s_capture_point;
      capture;
   endsequence

   sequence s_taken_at(logic [23:0] lo, logic [23:0] hi);
      taken && in_range(req_addr, lo, hi);
   endsequence

   property p_reserved_hole;
      s_taken_at(24'h040000, 24'h0cffff) |=>
         rsp_valid && rsp_reserved && rsp_region == region_reserved;
   endproperty
   a_reserved_hole: assert property (p_reserved_hole)
      else $error("Reserved address not flagged.");

   property p_prog_flash;
      s_taken_at(PROG_FLASH_LO, PROG_FLASH_HI) |=>
         rsp_region == region_prog_flash && rsp_zone == zone_static0;
   endproperty
   a_prog_flash: assert property (p_prog_flash)
      else $error("Program flash decode wrong.");

   property p_data_flash;
      s_taken_at(DATA_FLASH_LO, DATA_FLASH_HI) |=>
         rsp_region == region_data_flash && !rsp_reserved;
   endproperty
   a_data_flash: assert property (p_data_flash)
      else $error("Data flash decode wrong.");

   property p_seq_ram;
      s_taken_at(SEQ_RAM_LO, SEQ_RAM_HI) |=>
         rsp_region == region_sequencer_ram && rsp_zone == zone_none;
   endproperty
   a_seq_ram: assert property (p_seq_ram)
      else $error("Sequencer RAM decode wrong.");

   property p_can_end;
      taken && req_addr == CAN_HI ##1 taken && req_addr == CAN_HI + 24'h1
         |=> rsp_reserved;
   endproperty
   a_can_end: assert property (p_can_end)
      else $error("CAN area does not end where expected.");

   property p_link_regs;
      s_taken_at(LINK_REGS_LO, LINK_REGS_HI) |=>
         rsp_region == region_link_regs;
   endproperty
   a_link_regs: assert property (p_link_regs)
      else $error("Link register decode wrong.");

   property p_zone1;
      s_taken_at(EXT_ZONE1_LO, EXT_ZONE1_HI) and external_enabled |=>
         rsp_zone == zone_static1 && rsp_external;
   endproperty
   a_zone1: assert property (p_zone1)
      else $error("Zone 1 access not routed externally.");

   property p_zone2;
      s_taken_at(EXT_ZONE2_LO, EXT_ZONE2_HI) |=>
         rsp_zone == zone_static2 && rsp_external == external_enabled;
   endproperty
   a_zone2: assert property (p_zone2)
      else $error("Zone 2 access routing wrong.");

   property p_periph;
      s_taken_at(PERIPH_B_LO, PERIPH_B_HI) |=>
         rsp_region == region_peripheral && rsp_zone == zone_none;
   endproperty
   a_periph: assert property (p_periph)
      else $error("Peripheral decode wrong.");

   property p_bus_ctrl;
      s_taken_at(BUS_CTRL_LO, BUS_CTRL_HI) |=>
         rsp_region == region_bus_ctrl;
   endproperty
   a_bus_ctrl: assert property (p_bus_ctrl)
      else $error("Control register decode wrong.");

   property p_capture_once;
      s_capture_point |=> $rose(mode_ready) ##1 mode_ready[*4];
   endproperty
   a_capture_once: assert property (p_capture_once)
      else $error("Mode capture did not complete.");

   property p_code_rom;
      s_capture_point and pins_synced == CODE_INT_ROM |=>
         operating_mode == (flash_empty_flags == FLASH_EMPTY_ALL ?
         in_system_programming_mode : internal_rom_mode);
   endproperty
   a_code_rom: assert property (p_code_rom)
      else $error("Code 111 mode wrong.");

   property p_program_code;
      s_capture_point and pins_synced == CODE_PROGRAM |=>
         operating_mode == in_system_programming_mode && programming_vector;
   endproperty
   a_program_code: assert property (p_program_code)
      else $error("Code 110 did not give programming mode.");

   property p_vector;
      mode_ready |->
         programming_vector == (operating_mode == in_system_programming_mode);
   endproperty
   a_vector: assert property (p_vector)
      else $error("Reset vector selection wrong.");

   property p_develop_flash;
      s_taken_at(PROG_FLASH_LO, PROG_FLASH_HI) |=>
         rsp_external == (operating_mode == development_mode);
   endproperty
   a_develop_flash: assert property (p_develop_flash)
      else $error("Zone 0 routing wrong for mode.");

   property p_fallback;
      s_capture_point and (pins_synced == 3'h2 &&
         flash_empty_flags != FLASH_EMPTY_ALL) |=>
         operating_mode == internal_rom_mode;
   endproperty
   a_fallback: assert property (p_fallback)
      else $error("Unassigned code fallback wrong.");

endmodule // memory_map_and_boot_env

// ---- env_pin_model.sv ----
// Model of the board side of the environment select pins.
`timescale 1ns/1ps
module env_pin_model (
   input  wire logic       pin_float,
   input  wire logic [2:0] pin_value,
   output logic      [2:0] pins
);
   // Pull-ups win when nothing drives, so an open board boots as ones.
   assign pins = pin_float ? 3'h7 : pin_value;
endmodule // env_pin_model

// ---- memory_map_and_boot_env_tb.sv ----
// Self-checking bench for the address map and boot environment.
`timescale 1ns/1ps
module memory_map_and_boot_env_tb;
   import memory_map_pkg::*;
   logic        clk_sys, reset, clk_en, pin_float, req_valid, req_write;
   logic [2:0]  pin_value, pins;
   logic [1:0]  flash_empty_flags;
   logic [23:0] req_addr, rsp_addr;
   mode_e       operating_mode;
   region_e     rsp_region;
   zone_e       rsp_zone;
   logic        mode_ready, programming_vector, external_enabled;
   logic        rsp_valid, rsp_write, rsp_external, rsp_reserved;
   int          n_errors = 0;
   int          checks_done = 0;
   env_pin_model env_pin_model_i (.pin_float(pin_float),
      .pin_value(pin_value), .pins(pins));
   memory_map_and_boot_env memory_map_and_boot_env_i (.clk_sys(clk_sys),
      .reset(reset), .clk_en(clk_en), .environment_select_pins(pins),
      .flash_empty_flags(flash_empty_flags), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr),
      .operating_mode(operating_mode), .mode_ready(mode_ready),
      .programming_vector(programming_vector),
      .external_enabled(external_enabled), .rsp_valid(rsp_valid),
      .rsp_write(rsp_write), .rsp_addr(rsp_addr), .rsp_region(rsp_region),
      .rsp_zone(rsp_zone), .rsp_external(rsp_external),
      .rsp_reserved(rsp_reserved));
   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic mode_e exp_mode(input logic [2:0] c,
                                      input logic [1:0] e);
      if (c == 3'h0) return development_mode;
      if (c == 3'h1) return development_internal_memory_mode;
      if (c == 3'h6 || e == 2'h3) return in_system_programming_mode;
      if (c == 3'h3) return external_rom_mode;
      return internal_rom_mode;
   endfunction
   task automatic boot(input logic f, input logic [2:0] c,
                       input logic [1:0] e);
      reset = 1'b1;
      pin_float = f;
      pin_value = c;
      flash_empty_flags = e;
      repeat (2) @(negedge clk_sys);
      check(mode_ready, 1'b0);
      reset = 1'b0;
      repeat (4) @(negedge clk_sys);
      check(mode_ready, 1'b1);
   endtask
   // Caller stands at a falling edge; req_valid stays up for the next.
   task automatic acc(input logic [23:0] a, input region_e r,
                      input zone_e z, input logic x, input logic v);
      req_valid = 1'b1;
      req_addr = a;
      req_write = a[0];
      @(negedge clk_sys);
      check(rsp_valid, 1'b1);
      check({rsp_addr, rsp_write}, {a, a[0]});
      check({rsp_region, rsp_zone, rsp_external, rsp_reserved},
            {r, z, x, v});
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_boot_table;
      mode_e m;
      for (int c = 0; c < 8; c++) begin
         for (int e = 0; e < 4; e++) begin
            boot(1'b0, c[2:0], e[1:0]);
            m = exp_mode(c[2:0], e[1:0]);
            check(operating_mode, m);
            check(programming_vector,
                  m == in_system_programming_mode);
            check(external_enabled, m == external_rom_mode ||
                  m == development_mode ||
                  m == development_internal_memory_mode);
         end
      end
   endtask
   task automatic t_float;
      boot(1'b1, 3'h0, 2'h3);
      check(operating_mode, in_system_programming_mode);
      boot(1'b1, 3'h0, 2'h0);
      check(operating_mode, internal_rom_mode);
      pin_float = 1'b0;
      repeat (4) @(negedge clk_sys);
      check(operating_mode, internal_rom_mode);
   endtask
   task automatic t_map;
      boot(1'b0, 3'h3, 2'h0);
      acc(24'h000000, region_prog_flash, zone_static0, 0, 0);
      acc(24'h03ffff, region_prog_flash, zone_static0, 0, 0);
      acc(24'h040000, region_reserved, zone_none, 0, 1);
      acc(24'h0d0000, region_data_flash, zone_static0, 0, 0);
      acc(24'h0d2000, region_reserved, zone_none, 0, 1);
      acc(24'h0eebff, region_sequencer_ram, zone_none, 0, 0);
      acc(24'h0ef13f, region_can, zone_none, 0, 0);
      acc(24'h0ef140, region_reserved, zone_none, 0, 1);
      acc(24'h0ef1ff, region_link_regs, zone_none, 0, 0);
      acc(24'h3fffff, region_reserved, zone_none, 0, 1);
      acc(24'h400000, region_ext_zone1, zone_static1, 1, 0);
      acc(24'hfeffff, region_ext_zone2, zone_static2, 1, 0);
      acc(24'hff0000, region_reserved, zone_none, 0, 1);
      acc(24'hfff5ff, region_peripheral, zone_none, 0, 0);
      acc(24'hfffc00, region_peripheral, zone_none, 0, 0);
      acc(24'hfffaff, region_bus_ctrl, zone_none, 0, 0);
      req_valid = 1'b0;
      @(negedge clk_sys);
      check(rsp_valid, 1'b0);
   endtask
   task automatic t_modes;
      boot(1'b0, 3'h7, 2'h0);
      acc(24'h7fffff, region_ext_zone1, zone_static1, 0, 1);
      boot(1'b0, 3'h0, 2'h3);
      acc(24'h000100, region_prog_flash, zone_static0, 1, 0);
      boot(1'b0, 3'h1, 2'h3);
      acc(24'h000100, region_prog_flash, zone_static0, 0, 0);
      req_valid = 1'b0;
      clk_en = 1'b0;
      @(negedge clk_sys);
      req_valid = 1'b1;
      req_addr = 24'h400000;
      repeat (2) @(negedge clk_sys);
      check(rsp_valid, 1'b1);
      req_valid = 1'b0;
      clk_en = 1'b1;
      @(negedge clk_sys);
      check(rsp_valid, 1'b0);
      check(rsp_addr, 24'h000100);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      #100000;
      n_errors++;
      test_done();
   end
   initial begin
      reset = 1'b1;
      clk_en = 1'b1;
      pin_float = 1'b0;
      pin_value = 3'h7;
      flash_empty_flags = 2'h0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 24'h000000;
      @(negedge clk_sys);
      t_boot_table();
      t_float();
      t_map();
      t_modes();
      test_done();
   end
endmodule // memory_map_and_boot_env_tb
